/* common/eeprom_loader_pkg.sv */
package eeprom_loader_pkg;

   localparam int WORD_W = 16;
   localparam int ADDR_W = 6;

   // Word offsets inside the configuration memory
   localparam logic [5:0] OFS_CONFIG_PARAMETERS = 6'h00;
   localparam logic [5:0] OFS_BOARD_MAKER       = 6'h02;
   localparam logic [5:0] OFS_BOARD_PRODUCT     = 6'h03;
   localparam logic [5:0] OFS_FUNCTION_CONTROLS = 6'h0a;
   localparam logic [5:0] OFS_NODE_ADDR_0       = 6'h10;
   localparam logic [5:0] OFS_NODE_ADDR_1       = 6'h11;
   localparam logic [5:0] OFS_NODE_ADDR_2       = 6'h12;

   // Number of words fetched during auto initialization
   localparam int         LOAD_WORDS   = 7;
   localparam logic [2:0] LAST_WORD_IX = 3'h6;

   // Configuration parameters word fields
   localparam int CP_BACK_TO_BACK   = 0;
   localparam int CP_BELOW_ONE_MEG  = 1;
   localparam int CP_WINDOW_DISABLE = 2;
   localparam int CP_WAKE_COLD      = 3;
   localparam int CP_LIGHT_SLEEP    = 4;
   localparam int CP_DEEP_SLEEP     = 5;
   localparam int CP_WAKE_EVENT_EN  = 6;
   localparam int CP_MIN_GRANT_LSB  = 7;
   localparam int CP_MIN_GRANT_W    = 4;
   localparam int CP_MAX_LAT_LSB    = 11;
   localparam int CP_MAX_LAT_W      = 5;

   // Placement of those fields in the host-visible registers
   localparam int MIN_GRANT_REG_LSB = 4;
   localparam int MAX_LAT_REG_LSB   = 1;
   localparam int BUS_REG8_W        = 8;

   // Function controls word fields
   localparam int FC_LINK_POWER_SAVE = 0;
   localparam int FC_AUTO_CROSSOVER  = 1;
   localparam int FC_FINAL_ALERT_EN  = 3;
   localparam int FC_REPEAT_LSB      = 4;
   localparam int FC_REPEAT_W        = 3;
   localparam int FC_OPCODE_SEL      = 7;
   localparam int FC_DSP_LSB         = 8;
   localparam int FC_DSP_W           = 8;

   localparam logic [3:0] FINAL_ALERT_OPCODE_0 = 4'h1;
   localparam logic [3:0] FINAL_ALERT_OPCODE_1 = 4'h4;

   localparam logic [15:0] WORD_RESET = 16'h0000;

endpackage

/* common/word_fetch_if.sv */
interface word_fetch_if;
   logic        start;
   logic [5:0]  addr;
   logic        done;
   logic [15:0] data;

   modport loader
   (
      output start,
      output addr,
      input  done,
      input  data
   );

   modport fetcher
   (
      input  start,
      input  addr,
      output done,
      output data
   );
endinterface

/* verilog/word_fetch.sv */
module word_fetch
(
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   word_fetch_if.fetcher    fetch,
   output logic             o_word_req,
   output logic [5:0]       o_word_addr,
   input  wire logic        i_word_ack,
   input  wire logic [15:0] i_word_data
);

   logic        busy_r;
   logic [5:0]  addr_r;
   logic [15:0] data_r;
   logic        done_r;
   wire         take_word = busy_r & i_word_ack;

   // Request holds until the word reader acknowledges it
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         busy_r <= 1'b0;
         addr_r <= 6'h00;
      end
      else if (fetch.start & ~busy_r)
      begin
         busy_r <= 1'b1;
         addr_r <= fetch.addr;
      end
      else if (take_word)
      begin
         busy_r <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         data_r <= eeprom_loader_pkg::WORD_RESET;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= take_word;
         if (take_word)
         begin
            data_r <= i_word_data;
         end
      end
   end

   assign o_word_req  = busy_r;
   assign o_word_addr = addr_r;
   assign fetch.done  = done_r;
   assign fetch.data  = data_r;

endmodule

/* verilog/eeprom_autoinit_word_loader.sv */
// How it works
// [RULE_01] Fetch all words after reset, then flag ready
// [RULE_02] Word 0 bit 0 sets back-to-back capable
// [RULE_03] Word 0 bit 1 sets memory kind bit 1
// [RULE_04] Word 0 bit 2 disables memory window
// [RULE_05] Bits 3..5 load wake-cold, light, deep support
// [RULE_06] Bit 6 loads wake event enable
// [RULE_07] Bits 10..7 load minimum grant bits 7..4
// [RULE_08] Bits 15..11 load maximum latency bits 5..1
// [RULE_09] Control bit 0 saves power while link down
// [RULE_10] Control bit 1 enables cable auto crossover
// [RULE_11] Control bit 2 is reserved, image holds zero
// [RULE_12] Control bit 3 enables final alert frames
// [RULE_13] Bits 6..4 give final alert frame count
// [RULE_14] Bit 7 picks opcode 0001 or 0100
// [RULE_15] Words 0x10..0x12 build 48-bit node address
// [RULE_16] Product code word copied to its register
// [RULE_17] Maker code word 0x02 copied unchanged
// [RULE_18] Control bits 15..8 forwarded to PHY DSP
module eeprom_autoinit_word_loader
(
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic        i_link_up,
   output logic             o_word_req,
   output logic [5:0]       o_word_addr,
   input  wire logic        i_word_ack,
   input  wire logic [15:0] i_word_data,
   output logic             o_init_busy,
   output logic             o_init_done,
   output logic             o_back_to_back_capable,
   output logic [1:0]       o_memory_map_kind,
   output logic             o_memory_window_disable,
   output logic             o_wake_from_cold_support,
   output logic             o_light_sleep_support,
   output logic             o_deep_sleep_support,
   output logic             o_wake_event_enable,
   output logic [7:0]       o_minimum_grant_time,
   output logic [7:0]       o_maximum_latency_time,
   output logic             o_link_down_power_save,
   output logic             o_power_save_active,
   output logic             o_auto_crossover_enable,
   output logic             o_final_alert_enable,
   output logic [3:0]       o_final_alert_frames,
   output logic [3:0]       o_final_alert_opcode,
   output logic [7:0]       o_dsp_settings,
   output logic [47:0]      o_node_mac_address,
   output logic [15:0]      o_board_maker_code,
   output logic [15:0]      o_board_product_code
);

   typedef enum logic [1:0]
   {
      ST_ISSUE,
      ST_WAIT,
      ST_DONE
   } load_state_type;

   // Offset of the n-th word in the fetch order
   function automatic logic [5:0] offset_of(input logic [2:0] ix);
      logic [5:0] ofs;
      ofs = eeprom_loader_pkg::OFS_CONFIG_PARAMETERS;
      unique case (ix)
         3'h0: ofs = eeprom_loader_pkg::OFS_CONFIG_PARAMETERS;
         3'h1: ofs = eeprom_loader_pkg::OFS_BOARD_MAKER;
         3'h2: ofs = eeprom_loader_pkg::OFS_BOARD_PRODUCT;
         3'h3: ofs = eeprom_loader_pkg::OFS_FUNCTION_CONTROLS;
         3'h4: ofs = eeprom_loader_pkg::OFS_NODE_ADDR_0;
         3'h5: ofs = eeprom_loader_pkg::OFS_NODE_ADDR_1;
         3'h6: ofs = eeprom_loader_pkg::OFS_NODE_ADDR_2;
         default: ofs = eeprom_loader_pkg::OFS_CONFIG_PARAMETERS;
      endcase
      return ofs;
   endfunction

   // Picks one bit of a fetched word
   function automatic logic bit_of(input logic [15:0] w, input int pos);
      return w[pos];
   endfunction

   word_fetch_if fetch_bus ();

   word_fetch u_fetch
   (
      .i_mclk      (i_mclk),
      .i_rst       (i_rst),
      .fetch       (fetch_bus.fetcher),
      .o_word_req  (o_word_req),
      .o_word_addr (o_word_addr),
      .i_word_ack  (i_word_ack),
      .i_word_data (i_word_data)
   );

   load_state_type state_r;
   load_state_type state_nxt;
   logic [2:0]     index_r;
   logic [2:0]     index_nxt;

   logic [15:0]    config_parameters_word_r;
   logic [15:0]    function_controls_word_r;
   logic [47:0]    node_mac_address_words_r;
   logic [15:0]    board_maker_code_word_r;
   logic [15:0]    board_product_code_word_r;
   logic           power_save_r;
   logic [3:0]     opcode_r;

   wire            word_in     = fetch_bus.done;
   wire [15:0]     word_data   = fetch_bus.data;
   wire [5:0]      word_ofs    = offset_of(index_r);
   wire            last_word   = (index_r == eeprom_loader_pkg::LAST_WORD_IX);
   wire            loading     = (state_r != ST_DONE);

   // Which word the returned data belongs to
   wire            hit_config  = word_in & (word_ofs == eeprom_loader_pkg::OFS_CONFIG_PARAMETERS);
   wire            hit_maker   = word_in & (word_ofs == eeprom_loader_pkg::OFS_BOARD_MAKER);
   wire            hit_product = word_in & (word_ofs == eeprom_loader_pkg::OFS_BOARD_PRODUCT);
   wire            hit_func    = word_in & (word_ofs == eeprom_loader_pkg::OFS_FUNCTION_CONTROLS);
   wire            hit_addr0   = word_in & (word_ofs == eeprom_loader_pkg::OFS_NODE_ADDR_0);
   wire            hit_addr1   = word_in & (word_ofs == eeprom_loader_pkg::OFS_NODE_ADDR_1);
   wire            hit_addr2   = word_in & (word_ofs == eeprom_loader_pkg::OFS_NODE_ADDR_2);

   assign fetch_bus.start = (state_r == ST_ISSUE);
   assign fetch_bus.addr  = word_ofs;

   // Sequencer: one word at a time, in a fixed order
   always_comb
   begin
      state_nxt = state_r;
      index_nxt = index_r;
      unique case (state_r)
         ST_ISSUE:
         begin
            state_nxt = ST_WAIT;
         end
         ST_WAIT:
         begin
            if (word_in)
            begin
               if (last_word)
               begin
                  state_nxt = ST_DONE; // [RULE_01]
               end
               else
               begin
                  index_nxt = index_r + 3'h1;
                  state_nxt = ST_ISSUE;
               end
            end
         end
         ST_DONE:
         begin
            state_nxt = ST_DONE;
         end
         // The fourth code is unused; fall back to ST_ISSUE and reissue the current word
         default:
         begin
            state_nxt = ST_ISSUE;
         end
      endcase
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         state_r <= ST_ISSUE;
         index_r <= 3'h0;
      end
      else
      begin
         state_r <= state_nxt;
         index_r <= index_nxt;
      end
   end

   // Word captures; each register changes only on its own word
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         config_parameters_word_r <= eeprom_loader_pkg::WORD_RESET;
      end
      else if (hit_config)
      begin
         config_parameters_word_r <= word_data; // [RULE_01]
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         board_maker_code_word_r <= eeprom_loader_pkg::WORD_RESET;
      end
      else if (hit_maker)
      begin
         board_maker_code_word_r <= word_data; // [RULE_17]
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         board_product_code_word_r <= eeprom_loader_pkg::WORD_RESET;
      end
      else if (hit_product)
      begin
         board_product_code_word_r <= word_data; // [RULE_16]
      end
   end

   // The reserved bit is stored as read; nothing downstream looks at it
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         function_controls_word_r <= eeprom_loader_pkg::WORD_RESET;
      end
      else if (hit_func)
      begin
         function_controls_word_r <= word_data; // [RULE_11]
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         node_mac_address_words_r <= {3{eeprom_loader_pkg::WORD_RESET}};
      end
      else
      begin
         if (hit_addr0)
         begin
            node_mac_address_words_r[15:0] <= word_data; // [RULE_15]
         end
         if (hit_addr1)
         begin
            node_mac_address_words_r[31:16] <= word_data; // [RULE_15]
         end
         if (hit_addr2)
         begin
            node_mac_address_words_r[47:32] <= word_data; // [RULE_15]
         end
      end
   end

   // Decoded configuration fields
   wire [3:0] min_grant_field = config_parameters_word_r[eeprom_loader_pkg::CP_MIN_GRANT_LSB +:
                                                          eeprom_loader_pkg::CP_MIN_GRANT_W];
   wire [4:0] max_lat_field   = config_parameters_word_r[eeprom_loader_pkg::CP_MAX_LAT_LSB +:
                                                          eeprom_loader_pkg::CP_MAX_LAT_W];
   wire [2:0] repeat_field    = function_controls_word_r[eeprom_loader_pkg::FC_REPEAT_LSB +:
                                                          eeprom_loader_pkg::FC_REPEAT_W];
   wire       opcode_sel      = bit_of(function_controls_word_r, eeprom_loader_pkg::FC_OPCODE_SEL);
   wire       lps_enable      = bit_of(function_controls_word_r, eeprom_loader_pkg::FC_LINK_POWER_SAVE);
   wire [3:0] opcode_nxt      = opcode_sel ? eeprom_loader_pkg::FINAL_ALERT_OPCODE_1
                                           : eeprom_loader_pkg::FINAL_ALERT_OPCODE_0; // [RULE_14]

   // Link state comes from the PHY on this clock; held off until loading ends
   wire       power_save_nxt  = lps_enable & ~i_link_up & ~loading; // [RULE_09]

   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         power_save_r <= 1'b0;
         opcode_r     <= eeprom_loader_pkg::FINAL_ALERT_OPCODE_0;
      end
      else
      begin
         power_save_r <= power_save_nxt;
         opcode_r     <= opcode_nxt;
      end
   end

   assign o_init_busy = loading;
   assign o_init_done = ~loading; // [RULE_01]

   assign o_back_to_back_capable   = bit_of(config_parameters_word_r,
                                            eeprom_loader_pkg::CP_BACK_TO_BACK); // [RULE_02]
   // Bit 0 of the kind field is not loaded and reads zero
   assign o_memory_map_kind        = {bit_of(config_parameters_word_r,
                                             eeprom_loader_pkg::CP_BELOW_ONE_MEG), 1'b0}; // [RULE_03]
   assign o_memory_window_disable  = bit_of(config_parameters_word_r,
                                            eeprom_loader_pkg::CP_WINDOW_DISABLE); // [RULE_04]
   assign o_wake_from_cold_support = bit_of(config_parameters_word_r,
                                            eeprom_loader_pkg::CP_WAKE_COLD); // [RULE_05]
   assign o_light_sleep_support    = bit_of(config_parameters_word_r,
                                            eeprom_loader_pkg::CP_LIGHT_SLEEP); // [RULE_05]
   assign o_deep_sleep_support     = bit_of(config_parameters_word_r,
                                            eeprom_loader_pkg::CP_DEEP_SLEEP); // [RULE_05]
   assign o_wake_event_enable      = bit_of(config_parameters_word_r,
                                            eeprom_loader_pkg::CP_WAKE_EVENT_EN); // [RULE_06]
   assign o_minimum_grant_time     = {min_grant_field, 4'h0}; // [RULE_07]
   assign o_maximum_latency_time   = {2'h0, max_lat_field, 1'b0}; // [RULE_08]

   assign o_link_down_power_save   = lps_enable; // [RULE_09]
   assign o_power_save_active      = power_save_r; // [RULE_09]
   assign o_auto_crossover_enable  = bit_of(function_controls_word_r,
                                            eeprom_loader_pkg::FC_AUTO_CROSSOVER); // [RULE_10]
   assign o_final_alert_enable     = bit_of(function_controls_word_r,
                                            eeprom_loader_pkg::FC_FINAL_ALERT_EN); // [RULE_12]
   // Field value n means n+1 frames, so the full range reaches eight
   assign o_final_alert_frames     = {1'b0, repeat_field} + 4'h1; // [RULE_13]
   assign o_final_alert_opcode     = opcode_r; // [RULE_14]
   assign o_dsp_settings           = function_controls_word_r[eeprom_loader_pkg::FC_DSP_LSB +:
                                                              eeprom_loader_pkg::FC_DSP_W]; // [RULE_18]

   assign o_node_mac_address       = node_mac_address_words_r; // [RULE_15]
   assign o_board_maker_code       = board_maker_code_word_r; // [RULE_17]
   assign o_board_product_code     = board_product_code_word_r; // [RULE_16]

endmodule

/* verification/eeprom_loader_checker.sv */
module eeprom_loader_checker
(
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic        i_link_up,
   input  wire logic        o_word_req,
   input  wire logic [5:0]  o_word_addr,
   input  wire logic        i_word_ack,
   input  wire logic [15:0] i_word_data,
   input  wire logic        o_init_busy,
   input  wire logic        o_init_done,
   input  wire logic        o_back_to_back_capable,
   input  wire logic        o_memory_window_disable,
   input  wire logic [7:0]  o_minimum_grant_time,
   input  wire logic [7:0]  o_maximum_latency_time,
   input  wire logic        o_link_down_power_save,
   input  wire logic        o_power_save_active,
   input  wire logic [3:0]  o_final_alert_frames,
   input  wire logic [3:0]  o_final_alert_opcode,
   input  wire logic [47:0] o_node_mac_address,
   input  wire logic [15:0] o_board_maker_code
);
   logic take;
   assign take = o_word_req && i_word_ack;
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (i_rst);
   AST_REQ_HOLD: assert property (o_word_req && !i_word_ack |=> o_word_req && $stable(o_word_addr))
      else $error("request dropped or offset moved before ack");
   AST_REQ_DROP: assert property (take |=> !o_word_req [*2])
      else $error("request not released after ack");
   AST_NEXT_REQ: assert property (take && o_word_addr != 6'h12 |-> ##[1:4] o_word_req)
      else $error("next word not requested in time");
   AST_DONE: assert property (take && o_word_addr == 6'h12 |-> ##[1:3] (o_init_done && !o_init_busy))
      else $error("load not finished after last word");
   AST_IDLE: assert property (o_init_done |-> !o_word_req && !o_init_busy)
      else $error("request while loaded");
   AST_CFG_BITS: assert property (take && o_word_addr == 6'h00 |-> ##2
      o_back_to_back_capable == $past(i_word_data[0], 2) && o_memory_window_disable == $past(i_word_data[2], 2))
      else $error("config bits not loaded");
   AST_GRANT_LAT: assert property (take && o_word_addr == 6'h00 |-> ##2
      o_minimum_grant_time[7:4] == $past(i_word_data[10:7], 2)
      && o_maximum_latency_time[5:1] == $past(i_word_data[15:11], 2))
      else $error("grant or latency field wrong");
   AST_ALERT: assert property (take && o_word_addr == 6'h0a |-> ##3
      o_final_alert_frames == {1'b0, $past(i_word_data[6:4], 3)} + 4'h1
      && o_final_alert_opcode == ($past(i_word_data[7], 3) ? 4'h4 : 4'h1))
      else $error("final alert frames or opcode wrong");
   AST_MAC_LOW: assert property (take && o_word_addr == 6'h10 |-> ##2
      o_node_mac_address[15:0] == $past(i_word_data, 2))
      else $error("low address word wrong");
   AST_MAKER: assert property (take && o_word_addr == 6'h02 |-> ##2
      o_board_maker_code == $past(i_word_data, 2))
      else $error("maker code wrong");
   AST_POWER_SAVE: assert property (
      o_power_save_active == $past(o_link_down_power_save && !i_link_up && o_init_done))
      else $error("power save state wrong");
endmodule

bind eeprom_autoinit_word_loader eeprom_loader_checker u_checker
(
   .i_mclk(i_mclk), .i_rst(i_rst), .i_link_up(i_link_up), .o_word_req(o_word_req), .o_word_addr(o_word_addr),
   .i_word_ack(i_word_ack), .i_word_data(i_word_data), .o_init_busy(o_init_busy), .o_init_done(o_init_done),
   .o_back_to_back_capable(o_back_to_back_capable), .o_memory_window_disable(o_memory_window_disable),
   .o_minimum_grant_time(o_minimum_grant_time), .o_maximum_latency_time(o_maximum_latency_time),
   .o_link_down_power_save(o_link_down_power_save), .o_power_save_active(o_power_save_active),
   .o_final_alert_frames(o_final_alert_frames), .o_final_alert_opcode(o_final_alert_opcode),
   .o_node_mac_address(o_node_mac_address), .o_board_maker_code(o_board_maker_code)
);

/* verification/word_reader_model.sv */
module word_reader_model
(
   input  wire logic        i_mclk,
   input  wire logic        i_rst,
   input  wire logic        i_req,
   input  wire logic [5:0]  i_addr,
   input  wire logic [3:0]  i_delay,
   output logic             o_ack,
   output logic [15:0]      o_data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [0:63];
   logic [3:0]  wait_r;
   // Data is inverted every idle cycle so a sample outside the ack cycle shows up
   always_ff @(posedge i_mclk)
   begin
      if (i_rst)
      begin
         o_ack  <= 1'b0;
         wait_r <= 4'h0;
         o_data <= 16'h5a5a;
      end
      else if (!i_req || o_ack)
      begin
         o_ack  <= 1'b0;
         wait_r <= 4'h0;
         o_data <= ~o_data;
      end
      else if (wait_r == i_delay)
      begin
         o_ack  <= 1'b1;
         o_data <= mem[i_addr];
      end
      else
      begin
         wait_r <= wait_r + 4'h1;
         o_data <= ~o_data;
      end
   end
endmodule

/* verification/eeprom_autoinit_word_loader_tb.sv */
module eeprom_autoinit_word_loader_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic        i_mclk, i_rst, i_link_up, i_word_ack, o_word_req, o_init_busy, o_init_done;
   logic        o_back_to_back_capable, o_memory_window_disable, o_wake_from_cold_support;
   logic        o_light_sleep_support, o_deep_sleep_support, o_wake_event_enable;
   logic        o_link_down_power_save, o_power_save_active, o_auto_crossover_enable, o_final_alert_enable;
   logic [1:0]  o_memory_map_kind;
   logic [3:0]  o_final_alert_frames, o_final_alert_opcode, delay;
   logic [5:0]  o_word_addr;
   logic [7:0]  o_minimum_grant_time, o_maximum_latency_time, o_dsp_settings;
   logic [15:0] i_word_data, o_board_maker_code, o_board_product_code;
   logic [47:0] o_node_mac_address;
   logic [15:0] img [0:6];
   logic [5:0]  order [0:6];
   int          failures, samples_checked, seed, ix, acks;

   eeprom_autoinit_word_loader u_dut (.*);
   word_reader_model u_eeprom (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(o_word_req), .i_addr(o_word_addr),
      .i_delay(delay), .o_ack(i_word_ack), .o_data(i_word_data));

   always #5 i_mclk = ~i_mclk;

   function automatic logic [3:0] exp_frames(input logic [2:0] f);
      return {1'b0, f} + 4'h1;
   endfunction
   function automatic logic [3:0] exp_opcode(input logic b);
      return b ? 4'h4 : 4'h1;
   endfunction

   task automatic check(input logic [47:0] got, input logic [47:0] exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         failures++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic conclude;
      $display("checks %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Offsets must come in the fixed load order, once each
   always @(posedge i_mclk)
   begin
      if (i_rst)
         acks = 0;
      else if (o_word_req && i_word_ack)
      begin
         check(48'(o_word_addr), 48'(order[acks % 7]), "load order");
         acks++;
      end
   end

   task automatic run_image(input logic [3:0] dly, input logic abort);
      logic [15:0] c;
      logic [15:0] f;
      int n;
      c = img[0];
      f = img[3];
      for (n = 0; n < 7; n++)
         u_eeprom.mem[order[n]] = img[n];
      @(posedge i_mclk) #1 i_rst = 1'b1;
      delay = dly;
      repeat (3) @(posedge i_mclk);
      #1 i_rst = 1'b0;
      // Link down during the load must not start power saving early
      i_link_up = dly[0];
      check(48'({o_init_busy, o_init_done, o_word_req, o_power_save_active}), 48'h8, "reset state");
      // A reset in mid-load must restart from the first word
      if (abort)
      begin
         repeat (12) @(posedge i_mclk);
         #1 i_rst = 1'b1;
         repeat (3) @(posedge i_mclk);
         #1 i_rst = 1'b0;
         check(48'({o_init_busy, o_init_done, o_word_req}), 48'h4, "restart state");
      end
      for (n = 0; n < 400 && o_init_done !== 1'b1; n++)
         @(posedge i_mclk);
      if (n == 400)
      begin
         failures++;
         conclude();
      end
      repeat (4) @(posedge i_mclk);
      #1;
      check(48'(acks), 48'h7, "word count");
      check(48'(o_word_req), 48'h0, "idle request");
      check(48'(o_back_to_back_capable), 48'(c[0]), "back to back");
      check(48'(o_memory_map_kind), 48'({c[1], 1'b0}), "map kind");
      check(48'(o_memory_window_disable), 48'(c[2]), "window disable");
      check(48'({o_wake_from_cold_support, o_light_sleep_support, o_deep_sleep_support}),
         48'({c[3], c[4], c[5]}), "sleep support");
      check(48'(o_wake_event_enable), 48'(c[6]), "wake enable");
      check(48'(o_minimum_grant_time), 48'({c[10:7], 4'h0}), "min grant");
      check(48'(o_maximum_latency_time), 48'({2'h0, c[15:11], 1'b0}), "max latency");
      check(48'(o_link_down_power_save), 48'(f[0]), "power save bit");
      check(48'(o_auto_crossover_enable), 48'(f[1]), "crossover");
      check(48'(o_final_alert_enable), 48'(f[3]), "alert enable");
      check(48'(o_final_alert_frames), 48'(exp_frames(f[6:4])), "alert frames");
      check(48'(o_final_alert_opcode), 48'(exp_opcode(f[7])), "alert opcode");
      check(o_node_mac_address, {img[6], img[5], img[4]}, "node address");
      check(48'(o_board_product_code), 48'(img[2]), "product code");
      check(48'(o_board_maker_code), 48'(img[1]), "maker code");
      check(48'(o_dsp_settings), 48'(f[15:8]), "dsp settings");
      i_link_up = 1'b0;
      repeat (2) @(posedge i_mclk);
      #1 check(48'(o_power_save_active), 48'(f[0]), "link down saving");
      i_link_up = 1'b1;
      repeat (2) @(posedge i_mclk);
      #1 check(48'(o_power_save_active), 48'h0, "link up awake");
   endtask

   initial
   begin
      i_mclk = 1'b0;
      i_rst = 1'b1;
      i_link_up = 1'b1;
      delay = 4'h0;
      seed = 32'he3d8;
      failures = 0;
      samples_checked = 0;
      acks = 0;
      order = '{6'h00, 6'h02, 6'h03, 6'h0a, 6'h10, 6'h11, 6'h12};
      // First two images are the all-zero corner and all-one apart from reserved control bit 2
      for (ix = 0; ix < 14; ix++)
      begin
         for (int w = 0; w < 7; w++)
            img[w] = (ix == 0) ? 16'h0000 : (ix == 1) ? 16'hffff : 16'($random(seed));
         img[3][2] = 1'b0;
         run_image((ix < 2) ? 4'h0 : 4'($random(seed) & 7), ix == 3);
      end
      conclude();
   end
endmodule
